// [rtl/omr_pkg.sv]
// omr_pkg: address map, field positions and reset values of the motion sensor register bank.
// assumes one 40 MHz clock domain; the serial port is sampled in that domain.
package omr_pkg;
   localparam int          CLOCK_MHZ          = 40;
   localparam int          WORD_W             = 8;
   localparam int          ADDR_W             = 7;

   localparam logic [6:0]  ADDR_PART_IDENTITY = 7'h00;
   localparam logic [6:0]  ADDR_SILICON_REV   = 7'h01;
   localparam logic [6:0]  ADDR_MOTION_STATUS = 7'h02;
   localparam logic [6:0]  ADDR_X_DISP        = 7'h03;
   localparam logic [6:0]  ADDR_Y_DISP        = 7'h04;
   localparam logic [6:0]  ADDR_SURF_QUALITY  = 7'h05;
   localparam logic [6:0]  ADDR_PIXEL_TOTAL   = 7'h06;
   localparam logic [6:0]  ADDR_BRIGHTEST     = 7'h07;
   localparam logic [6:0]  ADDR_CONFIG_MAIN   = 7'h0A;
   localparam logic [6:0]  ADDR_CONFIG_EXT    = 7'h0B;
   localparam logic [6:0]  ADDR_DEBUG_LOW     = 7'h0C;
   localparam logic [6:0]  ADDR_DEBUG_HIGH    = 7'h0D;
   localparam logic [6:0]  ADDR_EXPOSURE_LOW  = 7'h0E;
   localparam logic [6:0]  ADDR_EXPOSURE_HIGH = 7'h0F;
   localparam logic [6:0]  ADDR_FRAME_LOW     = 7'h10;
   localparam logic [6:0]  ADDR_FRAME_HIGH    = 7'h11;
   localparam logic [6:0]  ADDR_MOTION_FLUSH  = 7'h12;
   localparam logic [6:0]  ADDR_IMAGE_GRAB    = 7'h13;
   localparam logic [6:0]  ADDR_FW_LOAD_EN    = 7'h14;
   localparam logic [6:0]  ADDR_FMAX_LOW      = 7'h19;
   localparam logic [6:0]  ADDR_FMAX_HIGH     = 7'h1A;
   localparam logic [6:0]  ADDR_FMIN_LOW      = 7'h1B;
   localparam logic [6:0]  ADDR_FMIN_HIGH     = 7'h1C;
   localparam logic [6:0]  ADDR_EXPMAX_LOW    = 7'h1D;
   localparam logic [6:0]  ADDR_EXPMAX_HIGH   = 7'h1E;
   localparam logic [6:0]  ADDR_FW_REVISION   = 7'h1F;
   localparam logic [6:0]  ADDR_OBSERVATION   = 7'h3D;
   localparam logic [6:0]  ADDR_PART_INVERTED = 7'h3F;
   localparam logic [6:0]  ADDR_PIXEL_STREAM  = 7'h40;
   localparam logic [6:0]  ADDR_MOTION_BULK   = 7'h50;
   localparam logic [6:0]  ADDR_FW_DOWNLOAD   = 7'h60;

   localparam int          MOT_BIT            = 7;
   localparam int          OVF_BIT            = 4;
   localparam int          RES_BIT            = 0;
   localparam int          CFG_RES_BIT        = 4;
   localparam int          WRITE_FLAG_BIT     = 7;
   localparam logic [2:0]  LAST_BIT           = 3'h7;

   localparam logic [7:0]  RST_CONFIG_MAIN    = 8'h09;
   localparam logic [7:0]  RST_CONFIG_EXT     = 8'h00;
   localparam logic [7:0]  RST_FMAX_LOW       = 8'hE0;
   localparam logic [7:0]  RST_FMAX_HIGH      = 8'h2E;
   localparam logic [7:0]  RST_FMIN_LOW       = 8'h7E;
   localparam logic [7:0]  RST_FMIN_HIGH      = 8'h0E;
   localparam logic [7:0]  RST_EXPMAX_LOW     = 8'h00;
   localparam logic [7:0]  RST_EXPMAX_HIGH    = 8'h20;
   localparam logic [7:0]  RST_OBSERVATION    = 8'h00;
   localparam logic [7:0]  READ_ZERO          = 8'h00;
endpackage

// [rtl/omr_register_map.sv]
// omr_register_map: register bank of the optical motion sensor behind its four-wire serial port.
// assumes serial clock well below clock/4, a navigation core on the same clock, pins asynchronous.
`timescale 1ns/1ps
module omr_register_map import omr_pkg::*; #(
   parameter int         ACC_W          = 12,
   parameter logic [7:0] PART_IDENTITY  = 8'h5A,  // arbitrary value
   parameter logic [7:0] SILICON_REV    = 8'h01   // arbitrary value
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              ncsPin_n,
   input  wire logic              sclkPin,
   input  wire logic              mosiPin,
   input  wire logic              npdPin_n,
   output logic                   misoOut,
   output logic                   misoOe,
   input  wire logic              navStep,
   input  wire logic [7:0]        navDx,
   input  wire logic [7:0]        navDy,
   input  wire logic [7:0]        surfaceQuality,
   input  wire logic [7:0]        pixelTotalUpper,
   input  wire logic [7:0]        brightestPixel,
   input  wire logic [15:0]       debugOut,
   input  wire logic [15:0]       exposure,
   input  wire logic [15:0]       frameTime,
   input  wire logic [7:0]        firmwareRevision,
   output logic [7:0]             configMain,
   output logic [7:0]             configExtended,
   output logic [15:0]            frameTimeMax,
   output logic [15:0]            frameTimeMin,
   output logic [15:0]            exposureMax,
   output logic [7:0]             observationFlags,
   output logic                   countsPerInchFlag,
   output logic                   powerDownState,
   output logic                   imageGrabStrobe,
   output logic                   firmwareLoadStrobe,
   output logic                   firmwareByteStrobe,
   output logic [7:0]             firmwareData
);

   if (ACC_W < 9 || ACC_W > 24) begin : gAccCheck
      $error("ACC_W must lie between 9 and 24");
   end

   localparam logic [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
   localparam logic [ACC_W-1:0] ACC_MIN = {1'b1, {(ACC_W-1){1'b0}}};

   typedef struct packed {
      logic             ncsMeta;
      logic             ncsSync;
      logic             sclkMeta;
      logic             sclkSync;
      logic             sclkPrev;
      logic             mosiMeta;
      logic             mosiSync;
      logic             npdMeta;
      logic             npdSync;
      logic             npdPrev;
      logic [7:0]       shift;
      logic [2:0]       bitCnt;
      logic             isData;
      logic             isWrite;
      logic [6:0]       addr;
      logic [7:0]       outShift;
      logic             miso;
      logic [ACC_W-1:0] accX;
      logic [ACC_W-1:0] accY;
      logic [7:0]       dxHeld;
      logic [7:0]       dyHeld;
      logic             overflow;
      logic [7:0]       cfgMain;
      logic [7:0]       cfgExt;
      logic [7:0]       fmaxLow;
      logic [7:0]       fmaxHigh;
      logic [7:0]       fminLow;
      logic [7:0]       fminHigh;
      logic [7:0]       expMaxLow;
      logic [7:0]       expMaxHigh;
      logic [7:0]       observation;
      logic             grab;
      logic             fwLoad;
      logic             fwByte;
      logic [7:0]       fwData;
   } omr_state_type;

   omr_state_type stateFf;
   omr_state_type nxtState;

   logic          readStrobe;
   logic          writeStrobe;
   logic [6:0]    accessAddr;
   logic [7:0]    accessData;
   logic [7:0]    readValue;
   logic          satX;
   logic          satY;

   function automatic logic [7:0] clip8(input logic [ACC_W-1:0] a);
      logic [ACC_W-9:0] upper;
      upper = a[ACC_W-2:7];
      if (!a[ACC_W-1] && (upper != '0)) begin
         clip8 = 8'h7F;
      end else if (a[ACC_W-1] && (upper != '1)) begin
         clip8 = 8'h80;
      end else begin
         clip8 = a[7:0];
      end
   endfunction

   function automatic logic [ACC_W-1:0] sext8(input logic [7:0] v);
      sext8 = {{(ACC_W-8){v[7]}}, v};
   endfunction

   function automatic logic [ACC_W:0] satAdd(input logic [ACC_W-1:0] a, input logic [7:0] d);
      logic [ACC_W:0] sum;
      sum = {a[ACC_W-1], a} + {{(ACC_W-7){d[7]}}, d};
      if (sum[ACC_W] != sum[ACC_W-1]) begin
         satAdd = {1'b1, sum[ACC_W] ? ACC_MIN : ACC_MAX};
      end else begin
         satAdd = {1'b0, sum[ACC_W-1:0]};
      end
   endfunction

   always_comb begin
      logic [7:0]       byteIn;
      logic             sclkRise;
      logic             sclkFall;
      logic             dispRead;
      logic             pdEnter;
      logic [ACC_W-1:0] baseX;
      logic [ACC_W-1:0] baseY;
      logic [ACC_W:0]   addX;
      logic [ACC_W:0]   addY;
      byteIn      = {stateFf.shift[6:0], stateFf.mosiSync};
      sclkRise    = stateFf.sclkSync & ~stateFf.sclkPrev;
      sclkFall    = ~stateFf.sclkSync & stateFf.sclkPrev;
      dispRead    = 1'b0;
      pdEnter     = ~stateFf.npdSync & stateFf.npdPrev;
      baseX       = stateFf.accX;
      baseY       = stateFf.accY;
      addX        = '0;
      addY        = '0;
      readStrobe  = 1'b0;
      writeStrobe = 1'b0;
      satX        = 1'b0;
      satY        = 1'b0;
      nxtState    = stateFf;

      nxtState.ncsMeta  = ncsPin_n;
      nxtState.ncsSync  = stateFf.ncsMeta;
      nxtState.sclkMeta = sclkPin;
      nxtState.sclkSync = stateFf.sclkMeta;
      nxtState.sclkPrev = stateFf.sclkSync;
      nxtState.mosiMeta = mosiPin;
      nxtState.mosiSync = stateFf.mosiMeta;
      nxtState.npdMeta  = npdPin_n;
      nxtState.npdSync  = stateFf.npdMeta;
      nxtState.npdPrev  = stateFf.npdSync;
      nxtState.grab     = 1'b0;
      nxtState.fwLoad   = 1'b0;
      nxtState.fwByte   = 1'b0;

      // serial framing: address byte, then one data byte
      if (stateFf.ncsSync) begin
         nxtState.bitCnt = '0;
         nxtState.isData = 1'b0;
      end else if (sclkRise) begin
         nxtState.shift  = byteIn;
         nxtState.bitCnt = stateFf.bitCnt + 3'h1;
         if (stateFf.bitCnt == LAST_BIT) begin
            if (!stateFf.isData) begin
               nxtState.addr    = byteIn[ADDR_W-1:0];
               nxtState.isWrite = byteIn[WRITE_FLAG_BIT];
               nxtState.isData  = 1'b1;
               readStrobe       = ~byteIn[WRITE_FLAG_BIT];
            end else begin
               nxtState.isData  = 1'b0;
               writeStrobe      = stateFf.isWrite;
            end
         end
      end else if (sclkFall && stateFf.isData && !stateFf.isWrite) begin
         nxtState.miso     = stateFf.outShift[7];
         nxtState.outShift = {stateFf.outShift[6:0], 1'b0};
      end
      accessAddr = readStrobe ? byteIn[ADDR_W-1:0] : stateFf.addr;
      accessData = byteIn;

      // read multiplexer
      unique case (accessAddr)
         ADDR_PART_IDENTITY: readValue = PART_IDENTITY;
         ADDR_SILICON_REV:   readValue = SILICON_REV;
         ADDR_MOTION_STATUS: readValue = {(stateFf.accX != '0) || (stateFf.accY != '0), 2'b00,
                                          stateFf.overflow, 3'b000, stateFf.cfgMain[CFG_RES_BIT]};
         ADDR_X_DISP:        readValue = stateFf.dxHeld;
         ADDR_Y_DISP:        readValue = stateFf.dyHeld;
         ADDR_SURF_QUALITY:  readValue = surfaceQuality;
         ADDR_PIXEL_TOTAL:   readValue = pixelTotalUpper;
         ADDR_BRIGHTEST:     readValue = {2'b00, brightestPixel[5:0]};
         ADDR_CONFIG_MAIN:   readValue = stateFf.cfgMain;
         ADDR_CONFIG_EXT:    readValue = stateFf.cfgExt;
         ADDR_DEBUG_LOW:     readValue = debugOut[7:0];
         ADDR_DEBUG_HIGH:    readValue = debugOut[15:8];
         ADDR_EXPOSURE_LOW:  readValue = exposure[7:0];
         ADDR_EXPOSURE_HIGH: readValue = exposure[15:8];
         ADDR_FRAME_LOW:     readValue = frameTime[7:0];
         ADDR_FRAME_HIGH:    readValue = frameTime[15:8];
         ADDR_FMAX_LOW:      readValue = stateFf.fmaxLow;
         ADDR_FMAX_HIGH:     readValue = stateFf.fmaxHigh;
         ADDR_FMIN_LOW:      readValue = stateFf.fminLow;
         ADDR_FMIN_HIGH:     readValue = stateFf.fminHigh;
         ADDR_EXPMAX_LOW:    readValue = stateFf.expMaxLow;
         ADDR_EXPMAX_HIGH:   readValue = stateFf.expMaxHigh;
         ADDR_FW_REVISION:   readValue = firmwareRevision;
         ADDR_OBSERVATION:   readValue = stateFf.observation;
         ADDR_PART_INVERTED: readValue = ~PART_IDENTITY;
         default:            readValue = READ_ZERO;
      endcase
      if (readStrobe) begin
         nxtState.outShift = readValue;
      end

      // register writes; unlisted addresses touch nothing here except fwData, which every write loads
      if (writeStrobe) begin
         unique case (accessAddr)
            ADDR_CONFIG_MAIN: nxtState.cfgMain     = accessData;
            ADDR_CONFIG_EXT:  nxtState.cfgExt      = accessData;
            ADDR_FMAX_LOW:    nxtState.fmaxLow     = accessData;
            ADDR_FMAX_HIGH:   nxtState.fmaxHigh    = accessData;
            ADDR_FMIN_LOW:    nxtState.fminLow     = accessData;
            ADDR_FMIN_HIGH:   nxtState.fminHigh    = accessData;
            ADDR_EXPMAX_LOW:  nxtState.expMaxLow   = accessData;
            ADDR_EXPMAX_HIGH: nxtState.expMaxHigh  = accessData;
            ADDR_OBSERVATION: nxtState.observation = accessData;
            ADDR_IMAGE_GRAB:  nxtState.grab        = 1'b1;
            ADDR_FW_LOAD_EN:  nxtState.fwLoad      = 1'b1;
            ADDR_FW_DOWNLOAD: nxtState.fwByte      = 1'b1;
            default:          nxtState.grab        = 1'b0;
         endcase
         nxtState.fwData = accessData;
      end

      // motion accumulation, freeze on status read, clear on displacement read
      if (readStrobe && accessAddr == ADDR_MOTION_STATUS) begin
         nxtState.dxHeld = clip8(stateFf.accX);
         nxtState.dyHeld = clip8(stateFf.accY);
         baseX = stateFf.accX - sext8(clip8(stateFf.accX));
         baseY = stateFf.accY - sext8(clip8(stateFf.accY));
      end
      if (readStrobe && accessAddr == ADDR_X_DISP) begin
         nxtState.dxHeld = 8'h00;
         dispRead        = 1'b1;
      end
      if (readStrobe && accessAddr == ADDR_Y_DISP) begin
         nxtState.dyHeld = 8'h00;
         dispRead        = 1'b1;
      end
      if ((writeStrobe && accessAddr == ADDR_MOTION_FLUSH) || pdEnter) begin
         baseX           = '0;
         baseY           = '0;
         nxtState.dxHeld = 8'h00;
         nxtState.dyHeld = 8'h00;
      end
      nxtState.accX = baseX;
      nxtState.accY = baseY;
      if (navStep && stateFf.npdSync) begin
         addX          = satAdd(baseX, navDx);
         addY          = satAdd(baseY, navDy);
         nxtState.accX = addX[ACC_W-1:0];
         nxtState.accY = addY[ACC_W-1:0];
         satX          = addX[ACC_W];
         satY          = addY[ACC_W];
      end
      // overflow: a new saturation wins over the clear
      if (satX || satY) begin
         nxtState.overflow = 1'b1;
      end else if ((dispRead || writeStrobe && accessAddr == ADDR_MOTION_FLUSH)
                   && nxtState.accX != ACC_MAX && nxtState.accX != ACC_MIN
                   && nxtState.accY != ACC_MAX && nxtState.accY != ACC_MIN) begin
         nxtState.overflow = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stateFf             <= '0;
         stateFf.ncsMeta     <= 1'b1;
         stateFf.ncsSync     <= 1'b1;
         stateFf.sclkMeta    <= 1'b1;
         stateFf.sclkSync    <= 1'b1;
         stateFf.sclkPrev    <= 1'b1;
         stateFf.npdMeta     <= 1'b1;
         stateFf.npdSync     <= 1'b1;
         stateFf.npdPrev     <= 1'b1;
         stateFf.cfgMain     <= RST_CONFIG_MAIN;
         stateFf.cfgExt      <= RST_CONFIG_EXT;
         stateFf.fmaxLow     <= RST_FMAX_LOW;
         stateFf.fmaxHigh    <= RST_FMAX_HIGH;
         stateFf.fminLow     <= RST_FMIN_LOW;
         stateFf.fminHigh    <= RST_FMIN_HIGH;
         stateFf.expMaxLow   <= RST_EXPMAX_LOW;
         stateFf.expMaxHigh  <= RST_EXPMAX_HIGH;
         stateFf.observation <= RST_OBSERVATION;
      end else begin
         stateFf <= nxtState;
      end
   end

   assign misoOut            = stateFf.miso;
   assign misoOe             = ~stateFf.ncsSync;
   assign configMain         = stateFf.cfgMain;
   assign configExtended     = stateFf.cfgExt;
   assign frameTimeMax       = {stateFf.fmaxHigh, stateFf.fmaxLow};
   assign frameTimeMin       = {stateFf.fminHigh, stateFf.fminLow};
   assign exposureMax        = {stateFf.expMaxHigh, stateFf.expMaxLow};
   assign observationFlags   = stateFf.observation;
   assign countsPerInchFlag  = stateFf.cfgMain[CFG_RES_BIT];
   assign powerDownState     = ~stateFf.npdSync;
   assign imageGrabStrobe    = stateFf.grab;
   assign firmwareLoadStrobe = stateFf.fwLoad;
   assign firmwareByteStrobe = stateFf.fwByte;
   assign firmwareData       = stateFf.fwData;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence statusReadSeq;
      readStrobe && accessAddr == ADDR_MOTION_STATUS;
   endsequence

   sequence flushWriteSeq;
      writeStrobe && accessAddr == ADDR_MOTION_FLUSH;
   endsequence

   identity_fixed_a: assert property (readStrobe && accessAddr == ADDR_PART_IDENTITY
      |=> stateFf.outShift == PART_IDENTITY) else $error("part identity read wrong");
   revision_read_a: assert property (readStrobe && accessAddr == ADDR_SILICON_REV
      |=> stateFf.outShift == SILICON_REV) else $error("silicon revision read wrong");
   fw_revision_a: assert property (readStrobe && accessAddr == ADDR_FW_REVISION
      |=> stateFf.outShift == $past(firmwareRevision)) else $error("firmware revision read wrong");
   status_bits_a: assert property (statusReadSeq |=> stateFf.outShift[MOT_BIT] ==
      $past(stateFf.accX != '0 || stateFf.accY != '0) && stateFf.outShift[RES_BIT] ==
      $past(stateFf.cfgMain[CFG_RES_BIT]) && stateFf.outShift[OVF_BIT] == $past(stateFf.overflow))
      else $error("motion status bits wrong");
   status_reserved_a: assert property (statusReadSeq |=> stateFf.outShift[6:5] == 2'b00
      && stateFf.outShift[3:1] == 3'b000) else $error("status reserved bits not zero");
   freeze_disp_a: assert property (statusReadSeq |=> stateFf.dxHeld == clip8($past(stateFf.accX))
      && stateFf.dyHeld == clip8($past(stateFf.accY))) else $error("displacement not frozen");
   disp_clear_a: assert property (readStrobe && accessAddr == ADDR_X_DISP
      ##1 !(readStrobe && accessAddr == ADDR_MOTION_STATUS)
      |=> stateFf.dxHeld == 8'h00) else $error("x displacement not cleared by read");
   flush_motion_a: assert property (flushWriteSeq and !navStep |=> stateFf.accX == '0
      && stateFf.accY == '0 && stateFf.dxHeld == 8'h00) else $error("flush left motion");
   ovf_set_a: assert property (satX || satY |=> stateFf.overflow [*1])
      else $error("overflow flag not set");
   ovf_clear_a: assert property (readStrobe && accessAddr == ADDR_Y_DISP && !satX && !satY
      && !navStep && stateFf.accY != ACC_MAX && stateFf.accY != ACC_MIN && stateFf.accX != ACC_MAX
      && stateFf.accX != ACC_MIN |=> !stateFf.overflow) else $error("overflow flag not cleared");
   config_write_a: assert property (writeStrobe && accessAddr == ADDR_CONFIG_MAIN
      |=> configMain == $past(accessData) && countsPerInchFlag == $past(accessData[CFG_RES_BIT]))
      else $error("config write lost");
   reserved_read_a: assert property (readStrobe && accessAddr == 7'h08 |=> stateFf.outShift == READ_ZERO)
      else $error("reserved address not zero");

endmodule // omr_register_map

// [verification/omr_host_model.sv]
// omr_host_model: serial port master standing in for the controller.
// assumes mode 3 framing; the bench sets half, the sclk half period in clocks (at least 5).
`timescale 1ns/1ps
module omr_host_model (
   input  wire logic clock,
   output logic      ncsPin_n,
   output logic      sclkPin,
   output logic      mosiPin,
   input  wire logic misoPin
);
   int half = 6;
   initial begin
      ncsPin_n = 1'b1;
      sclkPin  = 1'b1;
      mosiPin  = 1'b1;
   end
   // command byte then data byte, msb first; sclk stands high outside frames
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] bits;
      bits = {cmd, wd};
      @(posedge clock) #2 ncsPin_n = 1'b0;
      repeat (4) @(posedge clock);
      for (int i = 15; i >= 0; i--) begin
         #2 sclkPin = 1'b0;
         mosiPin = bits[i];
         repeat (half) @(posedge clock);
         if (i < 8) rd[i] = misoPin;
         #2 sclkPin = 1'b1;
         repeat (half) @(posedge clock);
      end
      #2 mosiPin = ~mosiPin;
      repeat (3) @(posedge clock);
      #2 ncsPin_n = 1'b1;
      repeat (8) @(posedge clock);
   endtask
endmodule // omr_host_model

// [verification/test_optical_motion_register_map.sv]
// test_optical_motion_register_map: self-checking bench for the motion sensor register bank.
// assumes the host model frames every access; navigation steps come from the bench.
`timescale 1ns/1ps
module test_optical_motion_register_map;
   import omr_pkg::*;
   logic        clock = 1'b0, rst_n = 1'b0, npdPin_n = 1'b1, navStep = 1'b0;
   logic        ncsPin_n, sclkPin, mosiPin, misoOut, misoOe, misoPin, cpi, pwd, s0, s1, s2;
   logic [7:0]  navDx = 8'h00, navDy = 8'h00, sq, pix, bri, fwRev, cfgM, cfgE, obs, fwd, rd;
   logic [15:0] dbg, expo, ft, fMax, fMin, eMax;
   logic [7:0]  nGrab = 8'h00, nLoad = 8'h00, nByte = 8'h00;
   logic [6:0]  cfgA [9] = '{7'h0A, 7'h0B, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D, 7'h1E, 7'h3D};
   logic [7:0]  cfgV [9] = '{8'h09, 8'h00, 8'hE0, 8'h2E, 8'h7E, 8'h0E, 8'h00, 8'h20, 8'h00};
   logic [6:0]  resA [6] = '{7'h08, 7'h09, 7'h15, 7'h18, 7'h20, 7'h3E};
   int          seed = 32'h6C6E, nMismatch = 0, totalChecks = 0, cycles = 0, sx, sy, dx, dy;

   assign misoPin = misoOe ? misoOut : 1'b1; // pull-up when released
   omr_host_model host (.clock(clock), .ncsPin_n(ncsPin_n), .sclkPin(sclkPin), .mosiPin(mosiPin),
      .misoPin(misoPin));
   omr_register_map DUT (.clock(clock), .rst_n(rst_n), .ncsPin_n(ncsPin_n), .sclkPin(sclkPin),
      .mosiPin(mosiPin), .npdPin_n(npdPin_n), .misoOut(misoOut), .misoOe(misoOe), .navStep(navStep),
      .navDx(navDx), .navDy(navDy), .surfaceQuality(sq), .pixelTotalUpper(pix), .brightestPixel(bri),
      .debugOut(dbg), .exposure(expo), .frameTime(ft), .firmwareRevision(fwRev), .configMain(cfgM),
      .configExtended(cfgE), .frameTimeMax(fMax), .frameTimeMin(fMin), .exposureMax(eMax),
      .observationFlags(obs), .countsPerInchFlag(cpi), .powerDownState(pwd), .imageGrabStrobe(s0),
      .firmwareLoadStrobe(s1), .firmwareByteStrobe(s2), .firmwareData(fwd));

   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         nMismatch++;
         closeOut();
      end
   end
   // strobe pulse counters, held still until reset is released
   always @(posedge clock) begin
      if (rst_n) begin
         nGrab <= nGrab + {7'h00, s0};
         nLoad <= nLoad + {7'h00, s1};
         nByte <= nByte + {7'h00, s2};
      end
   end

   function automatic logic [7:0] stat(logic mot, logic ovf, logic res);
      return {mot, 2'b00, ovf, 3'b000, res};
   endfunction
   function automatic logic [7:0] clip(int v);
      return v > 127 ? 8'h7F : (v < -128 ? 8'h80 : v[7:0]);
   endfunction
   task automatic chk8(logic [7:0] got, logic [7:0] exp);
      totalChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdChk(logic [6:0] a, logic [7:0] exp);
      host.xfer({1'b0, a}, 8'h3C, rd);
      chk8(rd, exp);
   endtask
   task automatic wr(logic [6:0] a, logic [7:0] d);
      host.xfer({1'b1, a}, d, rd);
   endtask
   task automatic step(logic [7:0] x, logic [7:0] y);
      @(posedge clock) #2 navStep = 1'b1;
      navDx = x;
      navDy = y;
      @(posedge clock) #2 navStep = 1'b0;
   endtask
   task automatic endTest(string name);
      host.half = 5 + ($random(seed) & 3);
      $display("test %s done", name);
   endtask
   task automatic closeOut;
      $display("checks %0d mismatches %0d", totalChecks, nMismatch);
      if (nMismatch == 0 && totalChecks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      {sq, pix, bri, fwRev} = $random(seed);
      {dbg, expo} = $random(seed);
      ft = 16'($random(seed));
      repeat (20) @(posedge clock);
      #2 rst_n = 1'b1;
      repeat (4) @(posedge clock);
      rdChk(ADDR_PART_IDENTITY, 8'h5A);
      rdChk(ADDR_SILICON_REV, 8'h01);
      rdChk(ADDR_PART_INVERTED, 8'hA5);
      rdChk(ADDR_FW_REVISION, fwRev);
      rdChk(ADDR_SURF_QUALITY, sq);
      rdChk(ADDR_BRIGHTEST, {2'b00, bri[5:0]});
      rdChk(ADDR_PIXEL_TOTAL, pix);
      rdChk(ADDR_DEBUG_HIGH, dbg[15:8]);
      rdChk(ADDR_EXPOSURE_LOW, expo[7:0]);
      rdChk(ADDR_FRAME_HIGH, ft[15:8]);
      foreach (cfgA[i]) rdChk(cfgA[i], cfgV[i]);
      rdChk(ADDR_MOTION_STATUS, 8'h00);
      endTest("reset");
      foreach (resA[i]) begin
         wr(resA[i], 8'hFF);
         rdChk(resA[i], 8'h00);
      end
      wr(ADDR_PART_IDENTITY, 8'h00);
      rdChk(ADDR_PART_IDENTITY, 8'h5A);
      rdChk(ADDR_MOTION_FLUSH, 8'h00);
      endTest("reserved");
      foreach (cfgA[i]) begin
         cfgV[i] = 8'($random(seed));
         wr(cfgA[i], cfgV[i]);
         rdChk(cfgA[i], cfgV[i]);
      end
      chk8(cfgM, cfgV[0]);
      chk8(cfgE, cfgV[1]);
      chk8(fMax[7:0], cfgV[2]);
      chk8(fMax[15:8], cfgV[3]);
      chk8(fMin[7:0], cfgV[4]);
      chk8(fMin[15:8], cfgV[5]);
      chk8(eMax[7:0], cfgV[6]);
      chk8(eMax[15:8], cfgV[7]);
      chk8(obs, cfgV[8]);
      for (int r = 1; r >= 0; r--) begin
         wr(ADDR_CONFIG_MAIN, {3'b000, r[0], 4'h0});
         rdChk(ADDR_MOTION_STATUS, stat(1'b0, 1'b0, r[0]));
         chk8({7'h00, cpi}, {7'h00, r[0]});
      end
      wr(ADDR_IMAGE_GRAB, 8'h01);
      wr(ADDR_FW_LOAD_EN, 8'h1D);
      wr(ADDR_FW_DOWNLOAD, 8'hC3);
      chk8(fwd, 8'hC3);
      chk8(nGrab, 8'h01);
      chk8(nLoad, 8'h01);
      chk8(nByte, 8'h01);
      rdChk(ADDR_IMAGE_GRAB, 8'h00);
      endTest("config");
      repeat (3) begin
         sx = 0;
         sy = 0;
         repeat (3) begin
            dx = $random(seed) % 31;
            dy = $random(seed) % 31;
            sx += dx;
            sy += dy;
            step(dx[7:0], dy[7:0]);
         end
         rdChk(ADDR_MOTION_STATUS, stat(sx != 0 || sy != 0, 1'b0, 1'b0));
         rdChk(ADDR_X_DISP, clip(sx));
         rdChk(ADDR_Y_DISP, clip(sy));
         rdChk(ADDR_X_DISP, 8'h00);
         rdChk(ADDR_MOTION_STATUS, 8'h00);
      end
      step(8'h05, 8'h02);
      rdChk(ADDR_MOTION_STATUS, 8'h80);
      step(8'h09, 8'hFD);
      rdChk(ADDR_MOTION_STATUS, 8'h80);
      rdChk(ADDR_X_DISP, 8'h09);
      rdChk(ADDR_Y_DISP, 8'hFD);
      endTest("motion");
      repeat (20) step(8'h7F, 8'h80);
      rdChk(ADDR_MOTION_STATUS, 8'h90);
      rdChk(ADDR_X_DISP, 8'h7F);
      rdChk(ADDR_Y_DISP, 8'h80);
      rdChk(ADDR_MOTION_STATUS, 8'h80);
      wr(ADDR_MOTION_FLUSH, 8'($random(seed)));
      rdChk(ADDR_MOTION_STATUS, 8'h00);
      rdChk(ADDR_X_DISP, 8'h00);
      endTest("overflow");
      step(8'h11, 8'h22);
      @(posedge clock) #2 npdPin_n = 1'b0;
      repeat (4) @(posedge clock);
      chk8({7'h00, pwd}, 8'h01);
      step(8'h05, 8'h05);
      @(posedge clock) #2 npdPin_n = 1'b1;
      repeat (4) @(posedge clock);
      chk8({7'h00, pwd}, 8'h00);
      rdChk(ADDR_MOTION_STATUS, 8'h00);
      rdChk(ADDR_X_DISP, 8'h00);
      endTest("power down");
      closeOut();
   end
endmodule // test_optical_motion_register_map
